// ===== src/mx_bank.sv
// Behaviour
// - every mixer is the same four-input mixer with a source and a gain per input.
// - one mixer stands in front of each output path and each serial port transmit channel.
// - gain codes up to 0x20 give -32 dB, 1 dB steps to 0 dB at 0x40 and +16 dB at 0x50, then hold.
// - source code 0x00 in bits 7:0 is silence.
// - codes 0x10-0x13 are the input paths, 0x20-0x25, 0x28-0x2B, 0x30-0x31 the port receive channels.
// - codes 0x04-0x06 tones and haptics, 0x08-0x09 echo loop-backs, 0x0D noise.
// - bit 15 of each source register reads 1 while that input is enabled.
// - an enable that the system clock cannot carry is refused and running paths stay as they are.
// - converter and DSP aux inputs use the same codes but pass one source without gain.
// - port mixers sit at 0x0700-0x078F, output mixers at 0x0680-0x06CF.
`timescale 1ns/1ns
`default_nettype none
`include "mx_defines.svh"
module mx_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire mx_pkg::mx_srcs_t src_in,
	output mx_pkg::mx_out_t mix_out,
	output logic irq
);
	// map a register index to its kind and selector
	function automatic mx_pkg::mx_dec_t mx_decode(input logic [11:0] idx);
		mx_pkg::mx_dec_t d;
		logic [11:0] off;
		d.kind = mx_pkg::MX_NONE;
		d.sel = '0;
		off = '0;
		if (idx >= `MX_OUT_BASE && idx <= `MX_OUT_LAST) begin
			off = idx - `MX_OUT_BASE;
			d.kind = off[0] ? mx_pkg::MX_VOL : mx_pkg::MX_SRC;
			d.sel = off[7:1];
		end else if (idx >= `MX_SER_BASE && idx <= `MX_SER_LAST) begin
			off = idx - `MX_SER_BASE;
			d.kind = off[0] ? mx_pkg::MX_VOL : mx_pkg::MX_SRC;
			d.sel = off[7:1] + `MX_SER_SEL0;
		end else if (idx >= `MX_PASS_BASE && idx <= `MX_PASS_LAST) begin
			off = idx - `MX_PASS_BASE;
			d.kind = mx_pkg::MX_SRC;
			d.sel = off[6:0] + `MX_PASS_SEL0;
		end else if (idx == `MX_REG_RATE0) begin
			d.kind = mx_pkg::MX_RATE0;
		end else if (idx == `MX_REG_RATE1) begin
			d.kind = mx_pkg::MX_RATE1;
		end else if (idx == `MX_REG_BUDGET) begin
			d.kind = mx_pkg::MX_BUDGET;
		end else if (idx == `MX_REG_STAT) begin
			d.kind = mx_pkg::MX_STAT;
		end else if (idx == `MX_REG_MASK) begin
			d.kind = mx_pkg::MX_MASK;
		end else if (idx == `MX_REG_USED) begin
			d.kind = mx_pkg::MX_USED;
		end
		return d;
	endfunction

	mx_pkg::mx_state_t q, n;
	mx_pkg::mx_dec_t wdec, rdec;
	logic [6:0] wsel;
	logic refuse;
	logic [23:0] need;
	logic [1:0] strobe;
	logic [`MX_NSEL-1:0][`MX_SW-1:0] sel_smp;
	logic [`MX_NMIX-1:0][`MX_SW-1:0] mix_sum;
	logic [`MX_NMIX-1:0] mix_sat;
	logic [`MX_NMIX-1:0] mix_grp;
	logic sat_ev;
	logic stat_rd;

	// sample enables: group 0 output paths, group 1 serial ports
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_rate
			mx_rate u_rate (
				.hclk(hclk),
				.hresetn(hresetn),
				.period(q.rate[g]),
				.strobe(strobe[g])
			);
		end
	endgenerate

	// source selection; the code indexes the source bus directly
	generate
		for (g = 0; g < `MX_NSEL; g++) begin : gen_sel
			assign sel_smp[g] = (q.ena[g] && q.src[g] != `MX_SILENCE) ?
				src_in.smp[q.src[g]] : '0;
		end
	endgenerate

	// one identical mixer per output path and port channel
	generate
		for (g = 0; g < `MX_NMIX; g++) begin : gen_mix
			mx_pkg::mx_quad_t quad;
			assign quad.smp = sel_smp[4*g+3:4*g];
			assign quad.vol = q.vol[4*g+3:4*g];
			assign mix_grp[g] = (g < `MX_NOUT) ? strobe[0] : strobe[1];
			mx_mix u_mix (
				.quad(quad),
				.sum(mix_sum[g]),
				.sat(mix_sat[g])
			);
		end
	endgenerate

	assign wsel = wdec.sel;

	// a taken read of the status register, watched by the status checks below
	assign stat_rd = hsel && htrans[1] && hready && hsize == `MX_HSIZE_WORD && !hwrite
		&& rdec.kind == mx_pkg::MX_STAT;

	// register file, enable bookkeeping and sample update
	always_comb begin
		n = q;
		n.ready = 1'b1;
		n.resp = 1'b0;
		n.dph = 1'b0;
		refuse = 1'b0;
		wdec = mx_decode(q.didx);
		rdec = mx_decode(haddr[13:2]);
		need = (24'(q.used) + 24'h000001) * `MX_INPUT_COST;
		// write data phase
		if (q.dph) begin
			case (wdec.kind)
				mx_pkg::MX_SRC: begin
					n.src[wdec.sel] = hwdata[7:0];
					if (hwdata[7:0] == `MX_SILENCE) begin
						if (q.ena[wdec.sel]) begin
							n.ena[wdec.sel] = 1'b0;
							n.used = q.used - 8'h01;
						end
					end else if (!q.ena[wdec.sel]) begin
						// enabling costs clock; running inputs are never dropped
						if (need <= {8'h00, q.budget}) begin
							n.ena[wdec.sel] = 1'b1;
							n.used = q.used + 8'h01;
						end else begin
							refuse = 1'b1;
						end
					end
				end
				mx_pkg::MX_VOL: begin
					n.vol[wdec.sel] = hwdata[7:1];
				end
				mx_pkg::MX_RATE0: begin
					n.rate[0] = hwdata[15:0];
				end
				mx_pkg::MX_RATE1: begin
					n.rate[1] = hwdata[15:0];
				end
				mx_pkg::MX_BUDGET: begin
					n.budget = hwdata[15:0];
				end
				mx_pkg::MX_MASK: begin
					n.mask = hwdata[1:0];
				end
				default: begin
				end
			endcase
		end
		// address phase; only word transfers are taken
		if (hsel && htrans[1] && hready && hsize == `MX_HSIZE_WORD) begin
			if (hwrite) begin
				n.dph = 1'b1;
				n.didx = haddr[13:2];
			end else begin
				case (rdec.kind)
					mx_pkg::MX_SRC: begin
						n.rdata = 32'({q.ena[rdec.sel], 7'h00, q.src[rdec.sel]});
					end
					mx_pkg::MX_VOL: begin
						n.rdata = 32'({q.vol[rdec.sel], 1'b0});
					end
					mx_pkg::MX_RATE0: begin
						n.rdata = 32'(q.rate[0]);
					end
					mx_pkg::MX_RATE1: begin
						n.rdata = 32'(q.rate[1]);
					end
					mx_pkg::MX_BUDGET: begin
						n.rdata = 32'(q.budget);
					end
					mx_pkg::MX_STAT: begin
						n.rdata = 32'(q.stat);
						n.stat = '0;
					end
					mx_pkg::MX_MASK: begin
						n.rdata = 32'(q.mask);
					end
					mx_pkg::MX_USED: begin
						n.rdata = 32'(q.used);
					end
					default: begin
						n.rdata = '0;
					end
				endcase
			end
		end
		// mixers and pass-through inputs step on their sample enable
		sat_ev = 1'b0;
		for (int m = 0; m < `MX_NMIX; m++) begin
			if (mix_grp[m]) begin
				n.out.mix[m] = mix_sum[m];
				sat_ev = sat_ev | mix_sat[m];
			end
		end
		if (strobe[0]) begin
			for (int p = 0; p < `MX_NPASS; p++) begin
				n.out.pass[p] = sel_smp[`MX_NIN + p];
			end
		end
		// events set after the read clear, so a same-cycle event survives
		if (refuse) begin
			n.stat[`MX_EV_REFUSE] = 1'b1;
		end
		if (sat_ev) begin
			n.stat[`MX_EV_SAT] = 1'b1;
		end
		n.irq = |(n.stat & n.mask);
	end

	// single state register; gains start at unity, rates at a safe period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.vol <= {`MX_NIN{`MX_VOL_RST}};
			q.rate <= {`MX_RATE_RST, `MX_RATE_RST};
			q.budget <= `MX_BUDGET_RST;
			q.ready <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign hreadyout = q.ready;
	assign hrdata = q.rdata;
	assign hresp = q.resp;
	assign mix_out = q.out;
	assign irq = q.irq;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	irq_level_a: assert property (irq == |(q.stat & q.mask))
		else $error("irq does not follow masked status");

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered error");

	refuse_event_a: assert property (refuse |=> q.stat[`MX_EV_REFUSE])
		else $error("refused enable raised no event");

	refuse_flag_a: assert property (refuse |=> !q.ena[$past(wsel)])
		else $error("refused input shows enabled");

	accept_flag_a: assert property (
		(q.dph && wdec.kind == mx_pkg::MX_SRC && hwdata[7:0] != `MX_SILENCE && !refuse)
		|=> q.ena[$past(wsel)])
		else $error("affordable enable not taken");

	silence_clear_a: assert property (
		(q.dph && wdec.kind == mx_pkg::MX_SRC && hwdata[7:0] == `MX_SILENCE)
		|=> !q.ena[$past(wsel)])
		else $error("silence left input enabled");

	used_count_a: assert property (q.used == 8'($countones(q.ena)))
		else $error("enabled count out of step");

	mix_hold_a: assert property (!strobe[1] |=> $stable(q.out.mix[`MX_NOUT]))
		else $error("port mixer moved between samples");

	mute_mix_a: assert property ((strobe[0] && q.ena[3:0] == 4'h0) |=> q.out.mix[0] == '0)
		else $error("mixer with no enabled input not silent");

	// status and bus side
	stat_sticky_a: assert property ((q.stat[`MX_EV_REFUSE] && !stat_rd) |=> q.stat[`MX_EV_REFUSE])
		else $error("refuse status lost without a read");

	stat_clear_a: assert property ((stat_rd && !refuse && !sat_ev) |=> q.stat == 2'b00)
		else $error("status read did not clear");

	stat_read_a: assert property (stat_rd |=> hrdata == 32'($past(q.stat)))
		else $error("status read returned wrong value");

	mask_write_a: assert property ((q.dph && wdec.kind == mx_pkg::MX_MASK) |=>
		q.mask == $past(hwdata[1:0]))
		else $error("mask write did not land");

	rate_write_a: assert property ((q.dph && wdec.kind == mx_pkg::MX_RATE0) |=>
		q.rate[0] == $past(hwdata[15:0]))
		else $error("rate write did not land");

	budget_write_a: assert property ((q.dph && wdec.kind == mx_pkg::MX_BUDGET) |=>
		q.budget == $past(hwdata[15:0]))
		else $error("budget write did not land");

	vol_write_a: assert property ((q.dph && wdec.kind == mx_pkg::MX_VOL) |=>
		q.vol[$past(wsel)] == $past(hwdata[7:1]))
		else $error("gain write did not land");

	// enable bookkeeping
	refuse_cause_a: assert property (refuse |-> need > {8'h00, q.budget})
		else $error("enable refused within budget");

	ena_keep_a: assert property (
		(q.ena[0] && !(q.dph && wdec.kind == mx_pkg::MX_SRC && wdec.sel == 7'h00
		&& hwdata[7:0] == `MX_SILENCE)) |=> q.ena[0])
		else $error("running input dropped");

	used_drop_a: assert property (
		(q.dph && wdec.kind == mx_pkg::MX_SRC && hwdata[7:0] == `MX_SILENCE && q.ena[wdec.sel])
		|=> q.used == $past(q.used) - 8'h01)
		else $error("disable did not lower the count");

	// sample path
	sat_event_a: assert property (sat_ev |=> q.stat[`MX_EV_SAT])
		else $error("saturation raised no event");

	sat_clamp_a: assert property ((mix_grp[12] && mix_sat[12]) |=>
		(q.out.mix[12] == `MX_SW'(`MX_SMP_MAX) || q.out.mix[12] == `MX_SW'(`MX_SMP_MIN)))
		else $error("saturated mixer not clamped");

	pass_hold_a: assert property (!strobe[0] |=> $stable(q.out.pass))
		else $error("pass-through moved between samples");

	pass_copy_a: assert property (strobe[0] |=> q.out.pass[0] == $past(sel_smp[`MX_NIN]))
		else $error("pass-through did not take its source");

	pass_silent_a: assert property ((strobe[0] && !q.ena[`MX_NIN]) |=> q.out.pass[0] == '0)
		else $error("disabled pass-through not silent");
endmodule
`default_nettype wire

// ===== include/mx_defines.svh
`ifndef MX_DEFINES_SVH
`define MX_DEFINES_SVH
// bank shape
`define MX_NOUT 10
`define MX_NSER 18
`define MX_NMIX 28
`define MX_NIN 112
`define MX_NPASS 8
`define MX_NSEL 120
`define MX_NCODE 256
`define MX_SW 24
// register indexes (byte address = 4 * index)
`define MX_OUT_BASE 12'h680
`define MX_OUT_LAST 12'h6CF
`define MX_SER_BASE 12'h700
`define MX_SER_LAST 12'h78F
`define MX_PASS_BASE 12'hB00
`define MX_PASS_LAST 12'hB07
`define MX_REG_RATE0 12'hB70
`define MX_REG_RATE1 12'hB71
`define MX_REG_BUDGET 12'hB72
`define MX_REG_STAT 12'hB73
`define MX_REG_MASK 12'hB74
`define MX_REG_USED 12'hB75
`define MX_SER_SEL0 7'h28
`define MX_PASS_SEL0 7'h70
// fields and reset values
`define MX_SILENCE 8'h00
`define MX_VOL_RST 7'h40
`define MX_VOL_MIN 7'h20
`define MX_VOL_MAX 7'h50
`define MX_VOL_OFFS 7'h1C
`define MX_DB_STEP 7'h06
`define MX_RATE_RST 16'h07CF
`define MX_BUDGET_RST 16'h07D0
`define MX_INPUT_COST 24'h000010
`define MX_HSIZE_WORD 3'h2
`define MX_EV_REFUSE 0
`define MX_EV_SAT 1
`define MX_SMP_MAX 32'sh007FFFFF
`define MX_SMP_MIN 32'shFF800000
// gain mantissas for 0..5 dB, unity is 15'h4000
`define MX_MANT0 15'h4000
`define MX_MANT1 15'h47CF
`define MX_MANT2 15'h5092
`define MX_MANT3 15'h5A67
`define MX_MANT4 15'h656F
`define MX_MANT5 15'h71CF
`define MX_GAIN_SHIFT 20
`endif

// ===== include/mx_pkg.sv
`include "mx_defines.svh"
package mx_pkg;
	typedef enum logic [3:0] {MX_NONE, MX_SRC, MX_VOL, MX_RATE0, MX_RATE1,
		MX_BUDGET, MX_STAT, MX_MASK, MX_USED} mx_kind_t;
	typedef struct packed {
		mx_kind_t kind;
		logic [6:0] sel;
	} mx_dec_t;
	typedef struct packed {
		logic [`MX_NCODE-1:0][`MX_SW-1:0] smp;
	} mx_srcs_t;
	typedef struct packed {
		logic [`MX_NMIX-1:0][`MX_SW-1:0] mix;
		logic [`MX_NPASS-1:0][`MX_SW-1:0] pass;
	} mx_out_t;
	typedef struct packed {
		logic [3:0][`MX_SW-1:0] smp;
		logic [3:0][6:0] vol;
	} mx_quad_t;
	typedef struct packed {
		logic [`MX_NSEL-1:0][7:0] src;
		logic [`MX_NIN-1:0][6:0] vol;
		logic [`MX_NSEL-1:0] ena;
		logic [1:0][15:0] rate;
		logic [15:0] budget;
		logic [7:0] used;
		logic [1:0] stat;
		logic [1:0] mask;
		logic irq;
		logic dph;
		logic [11:0] didx;
		logic [31:0] rdata;
		logic ready;
		logic resp;
		mx_out_t out;
	} mx_state_t;
endpackage

// ===== src/mx_rate.sv
`timescale 1ns/1ns
`default_nettype none
module mx_rate (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] period,
	output logic strobe
);
	typedef struct packed {
		logic [15:0] cnt;
		logic strobe;
	} mx_rate_st_t;
	mx_rate_st_t q, n;

	// one-cycle sample enable every period+1 clocks
	always_comb begin
		n = q;
		n.strobe = 1'b0;
		if (q.cnt == 16'h0000) begin
			n.cnt = period;
			n.strobe = 1'b1;
		end else begin
			n.cnt = q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign strobe = q.strobe;
endmodule
`default_nettype wire

// ===== src/mx_mix.sv
`timescale 1ns/1ns
`default_nettype none
`include "mx_defines.svh"
module mx_mix (
	input wire mx_pkg::mx_quad_t quad,
	output logic [`MX_SW-1:0] sum,
	output logic sat
);
	// dB index k = clamped code - 28, gain = mantissa(k mod 6) << (k / 6)
	function automatic logic [23:0] mx_gain(input logic [6:0] code);
		logic [6:0] c;
		logic [6:0] k;
		logic [14:0] mant;
		c = code;
		if (code < `MX_VOL_MIN) begin
			c = `MX_VOL_MIN;
		end else if (code > `MX_VOL_MAX) begin
			c = `MX_VOL_MAX;
		end
		k = c - `MX_VOL_OFFS;
		case (k % `MX_DB_STEP)
			7'h00: mant = `MX_MANT0;
			7'h01: mant = `MX_MANT1;
			7'h02: mant = `MX_MANT2;
			7'h03: mant = `MX_MANT3;
			7'h04: mant = `MX_MANT4;
			default: mant = `MX_MANT5;
		endcase
		return 24'(mant) << (k / `MX_DB_STEP);
	endfunction

	logic signed [47:0] prod [4];
	logic signed [31:0] acc;

	// gain scale each input, then saturating sum
	always_comb begin
		acc = '0;
		for (int i = 0; i < 4; i++) begin
			prod[i] = $signed(quad.smp[i]) * $signed({1'b0, mx_gain(quad.vol[i])});
			acc = acc + 32'(prod[i] >>> `MX_GAIN_SHIFT);
		end
		sat = (acc > `MX_SMP_MAX) || (acc < `MX_SMP_MIN);
		if (acc > `MX_SMP_MAX) begin
			sum = `MX_SW'(`MX_SMP_MAX);
		end else if (acc < `MX_SMP_MIN) begin
			sum = `MX_SW'(`MX_SMP_MIN);
		end else begin
			sum = acc[`MX_SW-1:0];
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "mx_defines.svh"
module tb;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	mx_pkg::mx_srcs_t src_in;
	mx_pkg::mx_out_t mix_out;
	int fails, tests_run;

	// single slave, so its ready is the bus ready
	mx_bank u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .src_in(src_in), .mix_out(mix_out), .irq(irq));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	// one ahb-lite single transfer; read data taken at the edge ending the data phase
	task automatic bus(input logic [11:0] idx, input logic wr_en, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {18'h0, idx, 2'h0};
		hwrite <= wr_en;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d);
		bus(idx, 1'b1, d);
	endtask

	task automatic rdchk(input logic [11:0] idx, input logic [31:0] exp);
		bus(idx, 1'b0, 32'h0);
		chk(rd, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// reference gain: clamp, then mantissa times power of two, 20 fraction bits
	function automatic logic [23:0] scale(input logic [23:0] s, input logic [6:0] c);
		logic [6:0] k;
		logic [14:0] m;
		longint p;
		k = (c < 7'h20) ? 7'h04 : ((c > 7'h50) ? 7'h34 : c - 7'h1C);
		case (k % 7'h06)
			7'h00: m = 15'h4000;
			7'h01: m = 15'h47CF;
			7'h02: m = 15'h5092;
			7'h03: m = 15'h5A67;
			7'h04: m = 15'h656F;
			default: m = 15'h71CF;
		endcase
		p = longint'($signed(s)) * (longint'(m) << (k / 7'h06));
		return p[43:20];
	endfunction

	// reset values and an unmapped index
	task automatic t_reset();
		rdchk(12'h680, 32'h0);
		rdchk(12'h681, 32'h80);
		rdchk(`MX_REG_RATE0, 32'h7CF);
		rdchk(`MX_REG_BUDGET, 32'h7D0);
		rdchk(`MX_REG_USED, 32'h0);
		rdchk(`MX_REG_STAT, 32'h0);
		rdchk(12'h000, 32'h0);
		// a byte-sized write is ignored
		hsize <= 3'h0;
		wr(`MX_REG_MASK, 32'h3);
		hsize <= `MX_HSIZE_WORD;
		rdchk(`MX_REG_MASK, 32'h0);
	endtask

	// output mixer 0, two inputs, gain codes across the clamp edges
	task automatic t_mix();
		logic [6:0] g [8] = '{7'h10, 7'h20, 7'h21, 7'h3F, 7'h50, 7'h51, 7'h7F, 7'h40};
		@(posedge hclk);
		src_in.smp[8'h10] <= 24'h010000;
		src_in.smp[8'h20] <= 24'h000400;
		// selectors all zero here; engines take a new period only at their next wrap
		wr(`MX_REG_RATE0, 32'h3);
		wr(`MX_REG_RATE1, 32'h3);
		ticks(2000);
		wr(12'h680, 32'h10);
		wr(12'h682, 32'h20);
		rdchk(12'h680, 32'h8010);
		rdchk(`MX_REG_USED, 32'h2);
		foreach (g[i]) begin
			wr(12'h683, {24'h0, g[i], 1'b0});
			ticks(10);
			chk({8'h0, mix_out.mix[0]}, {8'h0, 24'h010000 + scale(24'h000400, g[i])});
		end
	endtask

	// serial mixer 1 input 3, enable then back to silence
	task automatic t_serial();
		@(posedge hclk);
		src_in.smp[8'h30] <= 24'h000123;
		wr(12'h70E, 32'h30);
		ticks(10);
		chk({8'h0, mix_out.mix[11]}, 32'h123);
		wr(12'h70E, 32'h0);
		ticks(10);
		chk({8'h0, mix_out.mix[11]}, 32'h0);
		rdchk(`MX_REG_USED, 32'h2);
	endtask

	// first and last code of each listed source range, plus some codes 0x50-0xAF, through a pass-through selector, no gain applied
	task automatic t_codes();
		logic [7:0] c [26] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0D, 8'h10, 8'h13, 8'h20, 8'h25,
			8'h28, 8'h2B, 8'h30, 8'h31, 8'h50, 8'h53, 8'h58, 8'h5B, 8'h60, 8'h63, 8'h68, 8'h6D,
			8'hA0, 8'hA7, 8'hA8, 8'hAF};
		foreach (c[i]) begin
			@(posedge hclk);
			src_in.smp[c[i]] <= {8'h01, c[i], 8'h5A};
			wr(12'hB00, {24'h0, c[i]});
			ticks(10);
			chk({8'h0, mix_out.pass[0]}, {16'h0001, c[i], 8'h5A});
		end
		// put back the mixer 0 sources that the sweep overwrote
		src_in.smp[8'h10] <= 24'h010000;
		src_in.smp[8'h20] <= 24'h000400;
		wr(12'hB00, 32'h0);
		ticks(10);
		chk({8'h0, mix_out.pass[0]}, 32'h0);
	endtask

	// budget for two inputs only: a third enable is refused
	task automatic t_refuse();
		@(posedge hclk);
		src_in.smp[8'h11] <= 24'h070000;
		wr(`MX_REG_BUDGET, 32'h20);
		wr(`MX_REG_MASK, 32'h3);
		wr(12'h684, 32'h11);
		ticks(10);
		rdchk(12'h684, 32'h11);
		chk({31'h0, irq}, 32'h1);
		chk({8'h0, mix_out.mix[0]}, {8'h0, 24'h010000 + scale(24'h000400, 7'h40)});
		rdchk(`MX_REG_USED, 32'h2);
		rdchk(`MX_REG_STAT, 32'h1);
		ticks(2);
		chk({31'h0, irq}, 32'h0);
		rdchk(`MX_REG_STAT, 32'h0);
	endtask

	// saturation both ways on serial mixer 2, masked then unmasked
	task automatic t_sat();
		@(posedge hclk);
		src_in.smp[8'h12] <= 24'h600000;
		src_in.smp[8'h13] <= 24'h600000;
		wr(`MX_REG_BUDGET, 32'h7D0);
		wr(`MX_REG_MASK, 32'h1);
		wr(12'h710, 32'h12);
		wr(12'h712, 32'h13);
		ticks(10);
		chk({8'h0, mix_out.mix[12]}, 32'h7FFFFF);
		chk({31'h0, irq}, 32'h0);
		wr(`MX_REG_MASK, 32'h3);
		ticks(2);
		chk({31'h0, irq}, 32'h1);
		rdchk(`MX_REG_STAT, 32'h2);
		@(posedge hclk);
		src_in.smp[8'h12] <= 24'hA00000;
		src_in.smp[8'h13] <= 24'hA00000;
		ticks(10);
		chk({8'h0, mix_out.mix[12]}, 32'h800000);
	endtask

	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		fails = 0;
		tests_run = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `MX_HSIZE_WORD;
		hwdata = 32'h0;
		src_in = '0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_mix();
		t_serial();
		t_codes();
		t_refuse();
		t_sat();
		complete_run();
	end

	// about 2640 cycles expected; cut off well beyond
	initial begin
		#200000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
